// ### usbeds_pkg.sv
// Constants shared by the endpoint DMA and status block.
// Assumes a 32-bit AXI4-Lite register bus and a 10 MHz system clock.
package usbeds_pkg;

  // ------------------------------------------------------------
  // Widths
  // ------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam int STAT_W = 16;
  localparam int CNT_W = 16;
  localparam int NUM_CH = 3;
  localparam int FCFG_W = 20;

  // ------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------
  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_CHMAP = 12'h004;
  // Endpoint blocks start at 0x100, one per 0x20 bytes
  localparam logic [3:0] EP_PAGE = 4'h1;
  localparam logic [4:0] OFS_DMACFG = 5'h00;
  localparam logic [4:0] OFS_DMAEN = 5'h04;
  localparam logic [4:0] OFS_DMADIS = 5'h08;
  localparam logic [4:0] OFS_PKTCNT = 5'h0C;
  localparam logic [4:0] OFS_STATUS = 5'h10;
  localparam logic [4:0] OFS_FIFOTX = 5'h14;
  localparam logic [4:0] OFS_FIFORX = 5'h18;
  localparam logic [4:0] OFS_FIFOADDR = 5'h1C;

  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int CTRL_HOST = 0;
  localparam int CFG_DIR = 0;
  localparam int CFG_MODE = 1;
  localparam int CFG_AUTOSEND = 2;
  localparam int CFG_AUTOACK = 3;
  localparam int CFG_AUTOREQ = 4;
  localparam int CFG_RX_SHIFT = 8;
  localparam int SEL_TX = 0;
  localparam int SEL_RX = 1;
  localparam int CHMAP_STRIDE = 4;
  localparam int CHMAP_TX_SHIFT = 16;

  // Status word: receive flags in [7:0], transmit flags in [15:8].
  // Bits meaning an error always pass to the interrupt request.
  localparam logic [15:0] ERR_MASK = 16'h0F3F;

  // ------------------------------------------------------------
  // Reset values and fixed addresses
  // ------------------------------------------------------------
  localparam logic [31:0] RST_CHMAP = 32'h0000_0000;
  localparam logic [19:0] EP0_FIFO_CFG = 20'h3_0000;
  localparam logic [31:0] FIFO_PHYS_BASE = 32'h0000_0020;
  localparam logic [31:0] FIFO_PHYS_STRIDE = 32'h0000_0004;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic {TX_DIR = 1'h0, RX_DIR = 1'h1} usbeds_dir_e;
  typedef enum logic
  {
    DMA_SINGLE_PACKET_MODE = 1'h0,
    DMA_MULTI_PACKET_MODE = 1'h1
  } usbeds_mode_e;

endpackage : usbeds_pkg

// ### usbeds_cfg_mem.sv
// Small memory of FIFO start address and size, one word per FIFO.
// Assumes the writer and the reader share the system clock.
`timescale 1ns/100ps
module usbeds_cfg_mem
#(
  parameter int DEPTH = 8,
  parameter int WIDTH = 20,
  parameter int AW = $clog2(DEPTH)
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Write port
  input wire logic wrEn,
  input wire logic [AW-1:0] wrAddr,
  input wire logic [WIDTH-1:0] wrData,
  // Read port, data one cycle after the address
  input wire logic [AW-1:0] rdAddr,
  output logic [WIDTH-1:0] rdData
);

  typedef struct packed
  {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [WIDTH-1:0] rd;
  } usbeds_mem_s;

  usbeds_mem_s s_r;
  usbeds_mem_s s_nxt;

  always_comb
  begin
    s_nxt = s_r;
    if (wrEn)
    begin
      s_nxt.mem[wrAddr] = wrData;
    end
    s_nxt.rd = s_r.mem[rdAddr];
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  assign rdData = s_r.rd;

endmodule : usbeds_cfg_mem

// ### usbeds_axil.sv
// AXI4-Lite slave front end: one write and one read at a time.
// Assumes the register file decodes addresses combinationally.
`timescale 1ns/100ps
module usbeds_axil
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Write channels
  input wire logic [11:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // Read channels
  input wire logic [11:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Register file side
  output logic wrEn,
  output logic [11:0] wrAddr,
  output logic [31:0] wrData,
  output logic [31:0] wrMask,
  input wire logic wrErr,
  output logic [11:0] rdAddr,
  input wire logic [31:0] rdData,
  input wire logic rdErr
);

  typedef struct packed
  {
    logic awRdy, wRdy, awHave, wHave, wr, bVal;
    logic [1:0] bResp;
    logic [11:0] wAddr;
    logic [31:0] data, mask;
    logic arRdy, rWait, rLatch, rVal;
    logic [1:0] rResp;
    logic [11:0] rAddr;
    logic [31:0] rData;
  } usbeds_axil_s;

  usbeds_axil_s s_r;
  usbeds_axil_s s_nxt;

  always_comb
  begin
    s_nxt = s_r;
    s_nxt.wr = 1'b0;
    if (awvalid && s_r.awRdy)
    begin
      s_nxt.wAddr = awaddr;
      s_nxt.awHave = 1'b1;
      s_nxt.awRdy = 1'b0;
    end
    if (wvalid && s_r.wRdy)
    begin
      s_nxt.data = wdata;
      for (int i = 0; i < 4; i++)
        s_nxt.mask[8*i +: 8] = {8{wstrb[i]}};
      s_nxt.wHave = 1'b1;
      s_nxt.wRdy = 1'b0;
    end
    // Address and data held: commit and answer together
    if (s_r.awHave && s_r.wHave)
    begin
      s_nxt.wr = 1'b1;
      s_nxt.bVal = 1'b1;
      s_nxt.bResp = wrErr ? usbeds_pkg::RESP_SLVERR : usbeds_pkg::RESP_OKAY;
      s_nxt.awHave = 1'b0;
      s_nxt.wHave = 1'b0;
    end
    if (s_r.bVal && bready)
    begin
      s_nxt.bVal = 1'b0;
      s_nxt.awRdy = 1'b1;
      s_nxt.wRdy = 1'b0 | 1'b1;
    end
    // Reads wait one extra cycle for the registered config memory
    s_nxt.rWait = 1'b0;
    s_nxt.rLatch = s_r.rWait;
    if (arvalid && s_r.arRdy)
    begin
      s_nxt.rAddr = araddr;
      s_nxt.arRdy = 1'b0;
      s_nxt.rWait = 1'b1;
    end
    if (s_r.rLatch)
    begin
      s_nxt.rVal = 1'b1;
      s_nxt.rData = rdData;
      s_nxt.rResp = rdErr ? usbeds_pkg::RESP_SLVERR : usbeds_pkg::RESP_OKAY;
    end
    if (s_r.rVal && rready)
    begin
      s_nxt.rVal = 1'b0;
      s_nxt.arRdy = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      s_r <= '0;
      s_r.awRdy <= 1'b1;
      s_r.wRdy <= 1'b1;
      s_r.arRdy <= 1'b1;
    end
    else
      s_r <= s_nxt;
  end

  assign awready = s_r.awRdy;
  assign wready = s_r.wRdy;
  assign bvalid = s_r.bVal;
  assign bresp = s_r.bResp;
  assign arready = s_r.arRdy;
  assign rvalid = s_r.rVal;
  assign rresp = s_r.rResp;
  assign rdata = s_r.rData;
  assign wrEn = s_r.wr;
  assign wrAddr = s_r.wAddr;
  assign wrData = s_r.data;
  assign wrMask = s_r.mask;
  assign rdAddr = s_r.rAddr;

endmodule : usbeds_axil

// ### usbeds_top.sv
// Endpoint DMA control and status flags of a dual-role USB controller.
// Assumes link events and FIFO levels arrive synchronous to clk, and
// that a separate interrupt controller consumes the irq pulses.
//
// Implementation choices: the AXI4-Lite register port and the address map.
`timescale 1ns/100ps

module usbeds_top
#(
  parameter int NUM_EP = 4,
  parameter int EP_W = $clog2(NUM_EP)
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // AXI4-Lite register bus
  input wire logic [11:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [11:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // FIFO allocation
  input wire logic cfgWe,
  input wire logic [EP_W-1:0] cfgEp,
  input wire logic cfgRx,
  input wire logic [19:0] cfgWord,
  // Link events and FIFO levels per endpoint
  input wire logic [NUM_EP-1:0][15:0] linkEvt,
  input wire logic [NUM_EP-1:0] txPktDone,
  input wire logic [NUM_EP-1:0] rxPktDone,
  input wire logic [NUM_EP-1:0] txFullPkt,
  input wire logic [NUM_EP-1:0] txFifoSpace,
  input wire logic [NUM_EP-1:0] rxFifoEmpty,
  // DMA engine completions
  input wire logic [NUM_EP-1:0] txDmaDone,
  input wire logic [NUM_EP-1:0] rxDmaDone,
  // Endpoint actions
  output logic [NUM_EP-1:0] txSend,
  output logic [NUM_EP-1:0] rxAck,
  output logic [NUM_EP-1:0] inReq,
  output logic [NUM_EP-1:0] irq,
  // DMA channel requests
  output logic [2:0] rxChReq,
  output logic [2:0] txChReq
);

  typedef struct packed
  {
    logic hostMode;
    logic [31:0] chMap;
    logic [NUM_EP-1:0] txMode, rxMode, txAutoSend, rxAutoAck, rxAutoReq;
    logic [NUM_EP-1:0] txDmaEn, rxDmaEn;
    logic [NUM_EP-1:0][15:0] pktCnt, pktLeft;
    logic [NUM_EP-1:0][15:0] status;
    logic [NUM_EP-1:0] txFullPrev, rxEmptyPrev;
    logic [NUM_EP-1:0] txSend, rxAck, inReq, irq;
    logic [2:0] rxChReq, txChReq;
  } usbeds_top_s;

  usbeds_top_s s_r;
  usbeds_top_s s_nxt;

  logic wrEn;
  logic [11:0] wrAddr;
  logic [31:0] wrData;
  logic [31:0] wrMask;
  logic [31:0] wd;
  logic wrErr;
  logic [11:0] rdAddr;
  logic [31:0] rdData;
  logic rdErr;
  logic [19:0] memData;

  // ------------------------------------------------------------
  // Bus slave and FIFO configuration memory
  // ------------------------------------------------------------
  usbeds_axil u_axil
  (
    .clk(clk), .rst_b(rst_b),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .wrEn(wrEn), .wrAddr(wrAddr), .wrData(wrData), .wrMask(wrMask),
    .wrErr(wrErr), .rdAddr(rdAddr), .rdData(rdData), .rdErr(rdErr)
  );

  // Endpoint zero has a fixed FIFO, so its entries are never written
  usbeds_cfg_mem #(.DEPTH(2 * NUM_EP), .WIDTH(usbeds_pkg::FCFG_W)) u_mem
  (
    .clk(clk), .rst_b(rst_b),
    .wrEn(cfgWe && (cfgEp != '0)),
    .wrAddr({cfgEp, cfgRx}),
    .wrData(cfgWord),
    .rdAddr({rdAddr[5 +: EP_W], rdAddr[4:0] == usbeds_pkg::OFS_FIFORX}),
    .rdData(memData)
  );

  // ------------------------------------------------------------
  // Address decode
  // ------------------------------------------------------------
  function automatic logic addrOk(input logic [11:0] a);
    addrOk = (a == usbeds_pkg::OFS_CTRL) || (a == usbeds_pkg::OFS_CHMAP)
      || ((a[11:8] == usbeds_pkg::EP_PAGE) && (int'(a[7:5]) < NUM_EP)
      && (a[1:0] == 2'h0));
  endfunction : addrOk

  assign wrErr = !addrOk(wrAddr);
  assign rdErr = !addrOk(rdAddr);
  assign wd = wrData & wrMask;

  // ------------------------------------------------------------
  // Read mux; reads have no side effects
  // ------------------------------------------------------------
  always_comb
  begin
    logic [EP_W-1:0] re;
    re = rdAddr[5 +: EP_W];
    rdData = 32'h0000_0000;
    if (rdErr)
      rdData = 32'h0000_0000;
    else if (rdAddr == usbeds_pkg::OFS_CTRL)
      rdData[usbeds_pkg::CTRL_HOST] = s_r.hostMode;
    else if (rdAddr == usbeds_pkg::OFS_CHMAP)
      rdData = s_r.chMap;
    else
    begin
      case (rdAddr[4:0])
        usbeds_pkg::OFS_DMACFG:
        begin
          rdData[usbeds_pkg::CFG_MODE] = s_r.txMode[re];
          rdData[usbeds_pkg::CFG_AUTOSEND] = s_r.txAutoSend[re];
          rdData[usbeds_pkg::CFG_RX_SHIFT + usbeds_pkg::CFG_MODE] = s_r.rxMode[re];
          rdData[usbeds_pkg::CFG_RX_SHIFT + usbeds_pkg::CFG_AUTOACK] = s_r.rxAutoAck[re];
          rdData[usbeds_pkg::CFG_RX_SHIFT + usbeds_pkg::CFG_AUTOREQ] = s_r.rxAutoReq[re];
        end
        usbeds_pkg::OFS_DMAEN:
        begin
          rdData[usbeds_pkg::SEL_TX] = s_r.txDmaEn[re];
          rdData[usbeds_pkg::SEL_RX] = s_r.rxDmaEn[re];
        end
        usbeds_pkg::OFS_PKTCNT: rdData = {s_r.pktLeft[re], s_r.pktCnt[re]};
        usbeds_pkg::OFS_STATUS: rdData[15:0] = s_r.status[re];
        usbeds_pkg::OFS_FIFOTX, usbeds_pkg::OFS_FIFORX:
          rdData[19:0] = (re == '0) ? usbeds_pkg::EP0_FIFO_CFG : memData;
        usbeds_pkg::OFS_FIFOADDR:
          rdData = 32'(usbeds_pkg::FIFO_PHYS_BASE
            + usbeds_pkg::FIFO_PHYS_STRIDE * 32'(re));
        default: rdData = 32'h0000_0000;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Endpoint state
  // ------------------------------------------------------------
  always_comb
  begin
    logic wHit;
    logic wSel;
    logic req;
    logic [15:0] clr;
    logic [EP_W-1:0] ce;
    wSel = 1'b0;
    req = 1'b0;
    clr = 16'h0000;
    ce = '0;
    s_nxt = s_r;
    s_nxt.txSend = '0;
    s_nxt.rxAck = '0;
    s_nxt.inReq = '0;
    s_nxt.irq = '0;
    wHit = wrEn && !wrErr && (wrAddr[11:8] == usbeds_pkg::EP_PAGE);
    if (wrEn && (wrAddr == usbeds_pkg::OFS_CTRL) && wrMask[0])
      s_nxt.hostMode = wrData[usbeds_pkg::CTRL_HOST];
    if (wrEn && (wrAddr == usbeds_pkg::OFS_CHMAP))
      s_nxt.chMap = (s_r.chMap & ~wrMask) | wd;
    for (int e = 0; e < NUM_EP; e++)
    begin
      wSel = wHit && (int'(wrAddr[7:5]) == e);
      // Set wins over a clear in the same cycle
      clr = (wSel && (wrAddr[4:0] == usbeds_pkg::OFS_STATUS)) ? wd[15:0] : 16'h0000;
      s_nxt.status[e] = (s_r.status[e] & ~clr) | linkEvt[e];
      s_nxt.txFullPrev[e] = txFullPkt[e];
      s_nxt.txSend[e] = s_r.txAutoSend[e] && txFullPkt[e] && !s_r.txFullPrev[e];
      s_nxt.rxAck[e] = s_r.rxAutoAck[e] && rxPktDone[e];
      s_nxt.rxEmptyPrev[e] = rxFifoEmpty[e];
      req = s_r.hostMode && s_r.rxAutoReq[e] && s_r.rxDmaEn[e]
        && rxFifoEmpty[e] && !s_r.rxEmptyPrev[e];
      if (s_r.rxMode[e] == usbeds_pkg::DMA_MULTI_PACKET_MODE)
      begin
        req = req && (s_r.pktLeft[e] != 16'h0000);
        if (req)
          s_nxt.pktLeft[e] = s_r.pktLeft[e] - 16'h0001;
      end
      s_nxt.inReq[e] = req;
      // Packet events interrupt only without DMA; a DMA enable adds the DMA done terms
      s_nxt.irq[e] = (txPktDone[e] && !s_r.txDmaEn[e])
        || (rxPktDone[e] && !s_r.rxDmaEn[e])
        || ((linkEvt[e] & usbeds_pkg::ERR_MASK) != 16'h0000)
        || (txDmaDone[e] && s_r.txDmaEn[e])
        || (rxDmaDone[e] && s_r.rxDmaEn[e]
        && ((s_r.rxMode[e] == usbeds_pkg::DMA_SINGLE_PACKET_MODE)
        || (s_r.pktLeft[e] == 16'h0000)));
      if (wSel && (e != 0))
      begin
        case (wrAddr[4:0])
          usbeds_pkg::OFS_DMACFG:
            if (wrMask[0])
            begin
              if (wd[usbeds_pkg::CFG_DIR] == usbeds_pkg::RX_DIR)
              begin
                s_nxt.rxMode[e] = wd[usbeds_pkg::CFG_MODE];
                s_nxt.rxAutoAck[e] = wd[usbeds_pkg::CFG_AUTOACK];
                s_nxt.rxAutoReq[e] = wd[usbeds_pkg::CFG_AUTOREQ];
              end
              else
              begin
                s_nxt.txMode[e] = wd[usbeds_pkg::CFG_MODE];
                s_nxt.txAutoSend[e] = wd[usbeds_pkg::CFG_AUTOSEND];
              end
            end
          usbeds_pkg::OFS_DMAEN:
          begin
            if (wd[usbeds_pkg::SEL_TX])
              s_nxt.txDmaEn[e] = 1'b1;
            if (wd[usbeds_pkg::SEL_RX])
            begin
              s_nxt.rxDmaEn[e] = 1'b1;
              s_nxt.pktLeft[e] = s_r.pktCnt[e];
            end
          end
          usbeds_pkg::OFS_DMADIS:
          begin
            if (wd[usbeds_pkg::SEL_TX])
              s_nxt.txDmaEn[e] = 1'b0;
            if (wd[usbeds_pkg::SEL_RX])
              s_nxt.rxDmaEn[e] = 1'b0;
          end
          usbeds_pkg::OFS_PKTCNT:
            s_nxt.pktCnt[e] = (s_r.pktCnt[e] & ~wrMask[15:0]) | wd[15:0];
          default: ;
        endcase
      end
    end
    // Channels follow their mapped endpoint; index zero means unmapped
    for (int c = 0; c < usbeds_pkg::NUM_CH; c++)
    begin
      ce = s_r.chMap[usbeds_pkg::CHMAP_STRIDE * c +: EP_W];
      s_nxt.rxChReq[c] = (ce != '0) && s_r.rxDmaEn[ce] && !rxFifoEmpty[ce];
      ce = s_r.chMap[usbeds_pkg::CHMAP_TX_SHIFT + usbeds_pkg::CHMAP_STRIDE * c +: EP_W];
      s_nxt.txChReq[c] = (ce != '0) && s_r.txDmaEn[ce] && txFifoSpace[ce];
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      s_r <= '0;
      s_r.chMap <= usbeds_pkg::RST_CHMAP;
      // Idle level of an empty FIFO, so reset release shows no false edge
      s_r.rxEmptyPrev <= '1;
    end
    else
      s_r <= s_nxt;
  end

  assign txSend = s_r.txSend;
  assign rxAck = s_r.rxAck;
  assign inReq = s_r.inReq;
  assign irq = s_r.irq;
  assign rxChReq = s_r.rxChReq;
  assign txChReq = s_r.txChReq;

  // ------------------------------------------------------------
  // Checks on endpoint one, receive channel 0 and the reset state
  // ------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  logic seenClk_r;
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      seenClk_r <= 1'b0;
    else
      seenClk_r <= 1'b1;
  end

  sequence epWrite(logic [4:0] ofs);
    wrEn && (wrAddr == {usbeds_pkg::EP_PAGE, 3'h1, ofs});
  endsequence
  sequence epCalm;
    !txPktDone[1] && !rxPktDone[1] && (linkEvt[1] == 16'h0000)
      && !txDmaDone[1] && !rxDmaDone[1];
  endsequence

  chk_cfg_keeps_enable: assert property (epWrite(usbeds_pkg::OFS_DMACFG)
    |=> $stable(s_r.txDmaEn) && $stable(s_r.rxDmaEn) && $stable(s_r.pktCnt))
    else $error("DMA config write disturbed other settings");
  chk_chan_needs_en: assert property (s_r.rxChReq[0] |->
    $past(s_r.rxDmaEn[s_r.chMap[EP_W-1:0]]) && ($past(s_r.chMap[EP_W-1:0]) != '0))
    else $error("receive channel request without DMA enable");
  chk_reset_defaults: assert property (!seenClk_r |-> (s_r.txMode == '0)
    && (s_r.rxMode == '0) && (s_r.status == '0) && (s_r.rxDmaEn == '0))
    else $error("state not cleared by reset");
  chk_autosend_pulse: assert property ((s_r.txAutoSend[1] && txFullPkt[1]
    && !s_r.txFullPrev[1]) |=> s_r.txSend[1] ##1 !s_r.txSend[1] || txFullPkt[1])
    else $error("auto-send did not launch on full packet");
  chk_autoack_cause: assert property (s_r.rxAck[1]
    |-> $past(s_r.rxAutoAck[1]) && $past(rxPktDone[1]))
    else $error("acknowledge without auto-acknowledge and packet");
  chk_inreq_host: assert property (s_r.inReq[1] |-> $past(s_r.hostMode)
    && $past(s_r.rxAutoReq[1]) && ($past(s_r.pktLeft[1]) != 16'h0000
    || !$past(s_r.rxMode[1])))
    else $error("IN request outside host auto-request");
  chk_irq_no_dma: assert property ((rxPktDone[1] && !s_r.rxDmaEn[1])
    |=> s_r.irq[1])
    else $error("packet interrupt lost with DMA off");
  chk_irq_dma_quiet: assert property ((s_r.rxDmaEn[1] && s_r.txDmaEn[1])
    and epCalm |=> !s_r.irq[1])
    else $error("interrupt raised with DMA on and no DMA or error event");
  chk_enable_silent: assert property (epWrite(usbeds_pkg::OFS_DMAEN) and epCalm
    |=> !s_r.irq[1])
    else $error("DMA enable raised an interrupt");
  chk_status_sticky: assert property ((s_r.status[1][0]
    && !(wrEn && (wrAddr == {usbeds_pkg::EP_PAGE, 3'h1, usbeds_pkg::OFS_STATUS}) && wd[0]))
    || linkEvt[1][0] |=> s_r.status[1][0])
    else $error("status flag lost without clear");
  chk_disable_sel: assert property ((epWrite(usbeds_pkg::OFS_DMADIS)
    ##0 !wd[usbeds_pkg::SEL_RX]) |=> $stable(s_r.rxDmaEn[1]))
    else $error("disable changed an unselected direction");

endmodule : usbeds_top

// ### usbeds_far_model.sv
// Far side of endpoint 1: USB partner plus the system DMA engine.
// Assumes the bench asks for one packet at a time.
`timescale 1ns/100ps
module usbeds_far_model
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Bench requests
  input wire logic rxPkt,
  input wire logic txLoad,
  // Block side
  input wire logic txSend1,
  input wire logic rxReq,
  output logic [3:0] txPktDone,
  output logic [3:0] rxPktDone,
  output logic [3:0] txFullPkt,
  output logic [3:0] rxFifoEmpty,
  output logic [3:0] rxDmaDone
);
  // ----------------------------------------
  // Link and DMA behaviour
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      {txPktDone, rxPktDone, txFullPkt, rxDmaDone} <= '0;
      rxFifoEmpty <= 4'hF;
    end
    else
    begin
      rxPktDone <= {2'h0, rxPkt, 1'h0};
      txPktDone <= {2'h0, txSend1, 1'h0};
      // Drains only while the channel request stands, never unasked
      rxDmaDone <= {2'h0, rxReq & !rxFifoEmpty[1], 1'h0};
      if (rxPkt)
        rxFifoEmpty[1] <= 1'b0;
      else if (rxReq)
        rxFifoEmpty[1] <= 1'b1;
      if (txLoad)
        txFullPkt[1] <= 1'b1;
      else if (txSend1)
        txFullPkt[1] <= 1'b0;
    end
  end
endmodule : usbeds_far_model

// ### tb_top.sv
// Self-checking bench of the endpoint DMA and status block.
// Assumes the far side model stands in for link and DMA engine.
`timescale 1ns/100ps
module tb_top;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [11:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata, v;
  logic [31:0] seed = 32'h2a52;
  logic [3:0] wstrb = 4'hF;
  logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
  logic bready = 1'b1, rready = 1'b1;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic cfgWe = 1'b0, cfgRx = 1'b0, rxPkt = 1'b0, txLoad = 1'b0;
  logic [1:0] cfgEp = '0;
  logic [19:0] cfgWord = '0;
  logic [3:0][15:0] linkEvt = '0;
  logic [3:0] txPktDone, rxPktDone, txFullPkt, rxFifoEmpty, rxDmaDone;
  logic [3:0] txSend, rxAck, inReq, irq, txFifoSpace, txDmaDone;
  logic [2:0] rxChReq, txChReq;
  int error_cnt = 0, compares = 0;
  // ----------------------------------------
  // Harness
  // ----------------------------------------
  assign txFifoSpace = ~txFullPkt;
  assign txDmaDone = 4'h0;
  always #50 clk = ~clk;
  usbeds_top i_usbeds_top (.*);
  usbeds_far_model i_usbeds_far_model (.txSend1(txSend[1]), .rxReq(rxChReq[0]), .*);
  function logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  function logic [31:0] cfgExp(input logic [4:0] t, input logic [4:0] r);
    return {19'h0, r[4:3], 1'h0, r[1], 6'h0, t[2:1], 1'h0};
  endfunction : cfgExp
  function logic [1:0] respExp(input logic [11:0] a);
    return ((a < 12'h008) || (a[11:7] == 5'h02)) && (a[1:0] == 2'h0) ? 2'h0 : 2'h2;
  endfunction : respExp
  task print_verdict();
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : print_verdict
  task hang();
    error_cnt++;
    print_verdict();
  endtask : hang
  task chk(input logic [31:0] s, input logic [31:0] e, input string nm);
    compares++;
    if (s !== e)
    begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task wr(input logic [11:0] a, input logic [31:0] d);
    int n;
    awaddr <= a;
    wdata <= d;
    {awvalid, wvalid} <= 2'b11;
    for (n = 0; n < 50; n++)
    begin
      @(posedge clk);
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
      if (bvalid)
        break;
    end
    chk(bresp, respExp(a), "bresp");
    if (n == 50)
      hang();
  endtask : wr
  task rdc(input logic [11:0] a, input logic [31:0] e, input logic [1:0] r);
    int n;
    araddr <= a;
    arvalid <= 1'b1;
    for (n = 0; n < 50; n++)
    begin
      @(posedge clk);
      if (arready)
        arvalid <= 1'b0;
      if (rvalid)
        break;
    end
    chk(rdata, e, "rdata");
    chk(rresp, r, "rresp");
    if (n == 50)
      hang();
  endtask : rdc
  // Irq and ack one cycle after the packet, DMA results two later
  task pkt(input logic i2, input logic a2, input logic i4, input logic q4);
    rxPkt <= 1'b1;
    @(posedge clk);
    rxPkt <= 1'b0;
    repeat (2) @(posedge clk);
    chk(irq[1], i2, "irq");
    chk(rxAck[1], a2, "rxAck");
    repeat (2) @(posedge clk);
    chk(irq[1], i4, "dmaIrq");
    chk(inReq[1], q4, "inReq");
    repeat (4) @(posedge clk);
  endtask : pkt
  initial
  begin
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    rdc(12'h124, 32'h0, 2'h0);
    rdc(12'h13C, 32'h24, 2'h0);
    rdc(12'h114, 32'h0003_0000, 2'h0);
    rdc(12'h800, 32'h0, 2'h2);
    wr(12'h800, 32'hFFFF_FFFF);
    v = rnd();
    {cfgEp, cfgRx, cfgWord, cfgWe} <= {2'h1, 1'b1, v[19:0], 1'b1};
    @(posedge clk);
    cfgWe <= 1'b0;
    rdc(12'h138, {12'h0, v[19:0]}, 2'h0);
    wr(12'h004, 32'h0001_0001);
    pkt(1'b1, 1'b0, 1'b0, 1'b0);
    wr(12'h000, 32'h1);
    wr(12'h120, 32'h6);
    wr(12'h120, 32'h19);
    rdc(12'h120, cfgExp(5'h06, 5'h19), 2'h0);
    wr(12'h124, 32'h3);
    repeat (8) @(posedge clk);
    rdc(12'h124, 32'h3, 2'h0);
    chk({rxChReq, txChReq}, 32'h1, "chReq");
    pkt(1'b0, 1'b1, 1'b1, 1'b1);
    txLoad <= 1'b1;
    @(posedge clk);
    txLoad <= 1'b0;
    repeat (2) @(posedge clk);
    chk(txSend[1], 1'b1, "txSend");
    v = rnd();
    wr(12'h128, (v & 32'hFFFF_FFFC) | 32'h2);
    rdc(12'h124, 32'h1, 2'h0);
    pkt(1'b1, 1'b1, 1'b0, 1'b0);
    // Multi-packet receive: the leftover packet drains first and uses one count
    wr(12'h12C, 32'h2);
    wr(12'h120, 32'h1B);
    wr(12'h124, 32'h2);
    repeat (8) @(posedge clk);
    rdc(12'h12C, 32'h0001_0002, 2'h0);
    pkt(1'b0, 1'b1, 1'b0, 1'b1);
    pkt(1'b0, 1'b1, 1'b1, 1'b0);
    wr(12'h128, (v & 32'hFFFF_FFFD) | 32'h1);
    rdc(12'h124, 32'h2, 2'h0);
    chk(txChReq, 32'h0, "txChReq");
    v = rnd();
    linkEvt <= {32'h0, v[15:0] | 16'h0001, 16'h0};
    @(posedge clk);
    linkEvt <= '0;
    rdc(12'h130, {16'h0, v[15:0] | 16'h0001}, 2'h0);
    rdc(12'h130, {16'h0, v[15:0] | 16'h0001}, 2'h0);
    wr(12'h130, {16'h0, v[15:0] | 16'h0001});
    rdc(12'h130, 32'h0, 2'h0);
    print_verdict();
  end
endmodule : tb_top
